// ===== src/hoc_pkg.sv
// Purpose: Shared constants for the reference loop holdover controller
// Assumes: Register offsets are byte addresses on the 8-bit register port
// Notes: Field positions and widths are used by the controller and filter

package hoc_pkg;

   // Register offsets
   localparam logic [7:0] REG_EXIT_CFG = 8'h16;
   localparam logic [7:0] REG_ROUTE = 8'h14;
   localparam logic [7:0] REG_LOCK_TMR = 8'h28;
   localparam logic [7:0] REG_HOLD_CFG = 8'h29;
   localparam logic [7:0] REG_BUF_FIRST = 8'h0a;
   localparam logic [7:0] REG_STATE = 8'h82;

   // Field positions
   localparam int EXIT_CRIT_LSB = 0;
   localparam int EXIT_ACT_LSB = 2;
   localparam int HOLD_DAC_BIT = 2;
   localparam int BUF_EN_BIT = 0;

   // Widths and counts
   localparam int CONV_W = 7;
   localparam int ROUTE_W = 4;
   localparam int NBUF = 5;
   localparam int TMR_W = 5;
   localparam int IMP_W = 3;
   localparam int CNT_W = 32;
   localparam int AVG_SHIFT = 4;
   localparam int ACC_W = CONV_W + AVG_SHIFT;

   // Reset values
   localparam logic [7:0] EXIT_CFG_RST = 8'h00;
   localparam logic [7:0] HOLD_CFG_RST = 8'h00;
   localparam logic [TMR_W-1:0] LOCK_TMR_RST = 5'h0f;
   localparam logic [ROUTE_W-1:0] ROUTE_RST = 4'h0;
   localparam logic [IMP_W-1:0] IMP_LOW = 3'h0;
   localparam logic [IMP_W-1:0] IMP_HIGH = 3'h7;

   // Exit condition and procedure codes
   localparam logic [1:0] CRIT_LOS = 2'h0;
   localparam logic [1:0] CRIT_PHASE = 2'h1;
   localparam logic [1:0] ACT_RESET = 2'h0;
   localparam logic [1:0] ACT_SLIP = 2'h1;
   localparam logic [1:0] ACT_DAC = 2'h3;

   // Loop states, one-hot
   typedef enum logic [7:0] {
      ST_INIT = 8'h01,
      ST_PRELOAD = 8'h02,
      ST_ACQUIRE = 8'h04,
      ST_LOCKED = 8'h08,
      ST_HOLD_ENTRY = 8'h10,
      ST_HOLD = 8'h20,
      ST_EXIT_SLIP = 8'h40,
      ST_EXIT_RELEASE = 8'h80
   } hoc_state_t;

   // Readable state codes
   localparam logic [2:0] CODE_INIT = 3'h0;
   localparam logic [2:0] CODE_PRELOAD = 3'h1;
   localparam logic [2:0] CODE_ACQUIRE = 3'h2;
   localparam logic [2:0] CODE_LOCKED = 3'h3;
   localparam logic [2:0] CODE_HOLD_ENTRY = 3'h4;
   localparam logic [2:0] CODE_HOLD = 3'h5;
   localparam logic [2:0] CODE_EXIT = 3'h6;

endpackage

// ===== src/hoc_avg_filter.sv
// Purpose: Low-pass average of tuning voltage samples
// Assumes: One sample per clock while enabled
// Notes: Holds its value while disabled

`timescale 1ns/1ps
`default_nettype none

module hoc_avg_filter
   import hoc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Samples
   input wire logic en_i,
   input wire logic [CONV_W-1:0] sample_i,
   // Average
   output logic [CONV_W-1:0] avg_o
);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;

   always_comb
   begin
      acc_d = acc_q;
      if (en_i)
      begin
         acc_d = acc_q - (acc_q >> AVG_SHIFT) + ACC_W'(sample_i);
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         acc_q <= '0;
      end
      else
      begin
         acc_q <= acc_d;
      end
   end

   assign avg_o = acc_q[ACC_W-1:AVG_SHIFT];

endmodule

`default_nettype wire

// ===== src/hoc_ctrl.sv
// Purpose: Holdover control for the reference cleanup loop
// Assumes: clk_i is the common_rate_clock; all inputs synchronous to it
// Notes: Phase error sensor, signal-missing and slip detection are outside
// Function
// - Large phase error while locked tristates the charge pump at once
// - The same large phase error clears lock detect
// - Charge pump stays tristated throughout holdover
// - DAC mode: converter forces the held value until holdover exit
// - Holdover config bit 2 chooses tristate only or tristate plus DAC
// - Forced value is averaged tuning samples taken only while locked
// - Sensing and driving converter codes are seven bits
// - Exit config register holds exit condition and exit procedure fields
// - Condition 1, procedure 1: leave on no signal loss and low phase error
// - Condition 0, procedure 0: leave on no signal loss by divider reset
// - Condition 0, procedure 3: divider reset then DAC-assisted release
// - Slip procedure keeps pump tristated until slip, then re-engages
// - Divider reset procedure resets dividers and restarts without waiting
// - DAC release starts low impedance, then raises it step by step
// - Buffer enables for four references and oscillator sit at 0x0a..0x0e
// - All control logic runs on the common rate clock
// - Locked loop enters holdover on lock loss, signal loss, or switch
// - Current state always readable as a 3-bit code at 0x82

`timescale 1ns/1ps
`default_nettype none

module hoc_ctrl
   import hoc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   output logic [7:0] reg_rdata_o,
   // Loop status inputs
   input wire logic phase_err_large_i,
   input wire logic signal_missing_flag_i,
   input wire logic ref_switch_req_i,
   input wire logic cycle_slip_i,
   input wire logic [CONV_W-1:0] adc_code_i,
   // Loop controls
   output logic charge_pump_tristate_o,
   output logic lock_detect_o,
   output logic dac_force_o,
   output logic [CONV_W-1:0] dac_code_o,
   output logic [IMP_W-1:0] dac_impedance_o,
   output logic divider_reset_o,
   output logic [NBUF-1:0] ref_buffer_enable_o,
   output logic [ROUTE_W-1:0] reference_route_select_o,
   output logic [2:0] loop_state_code_o
);

   hoc_state_t state_q, state_d;
   logic cp_tri_q, cp_tri_d;
   logic lock_q, lock_d;
   logic dac_force_q, dac_force_d;
   logic div_rst_q, div_rst_d;
   logic [IMP_W-1:0] imp_q, imp_d;
   logic [CNT_W-1:0] lock_cnt_q, lock_cnt_d;
   logic [CNT_W-1:0] lock_target;
   logic [7:0] exit_cfg_q, exit_cfg_d;
   logic [7:0] hold_cfg_q, hold_cfg_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [ROUTE_W-1:0] route_q, route_d;
   logic [NBUF-1:0] buf_q, buf_d;
   logic [7:0] rdata_q, rdata_d;
   logic [2:0] code_q, code_d;
   logic [CONV_W-1:0] avg_code;
   logic [CONV_W-1:0] dac_code_q, dac_code_d;
   logic [1:0] exit_crit;
   logic [1:0] exit_act;
   logic use_dac;
   logic exit_ok;
   logic ref_ready;

   assign exit_crit = exit_cfg_q[EXIT_CRIT_LSB +: 2];
   assign exit_act = exit_cfg_q[EXIT_ACT_LSB +: 2];
   assign use_dac = hold_cfg_q[HOLD_DAC_BIT];
   assign lock_target = CNT_W'(1) << tmr_q;
   assign ref_ready = |(route_q & buf_q[ROUTE_W-1:0]);
   // Condition 1 also needs low phase error; other codes wait only for signal
   assign exit_ok = !signal_missing_flag_i && !(exit_crit == CRIT_PHASE && phase_err_large_i);

   // Averaging runs only while lock is reported
   hoc_avg_filter u_avg
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(lock_q),
      .sample_i(adc_code_i),
      .avg_o(avg_code)
   );

   // Register writes
   always_comb
   begin
      exit_cfg_d = exit_cfg_q;
      hold_cfg_d = hold_cfg_q;
      tmr_d = tmr_q;
      route_d = route_q;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            REG_EXIT_CFG: exit_cfg_d = reg_wdata_i;
            REG_HOLD_CFG: hold_cfg_d = reg_wdata_i;
            REG_LOCK_TMR: tmr_d = reg_wdata_i[TMR_W-1:0];
            REG_ROUTE: route_d = reg_wdata_i[ROUTE_W-1:0];
            default: ;
         endcase
      end
   end

   // One buffer-enable register per input
   genvar gi;
   generate
      for (gi = 0; gi < NBUF; gi++)
      begin : g_buf
         always_comb
         begin
            buf_d[gi] = buf_q[gi];
            if (reg_wr_i && reg_addr_i == REG_BUF_FIRST + 8'(gi))
            begin
               buf_d[gi] = reg_wdata_i[BUF_EN_BIT];
            end
         end
      end
   endgenerate

   // Register reads, answered one cycle after the address
   always_comb
   begin
      rdata_d = 8'h00;
      case (reg_addr_i)
         REG_EXIT_CFG: rdata_d = exit_cfg_q;
         REG_HOLD_CFG: rdata_d = hold_cfg_q;
         REG_LOCK_TMR: rdata_d = {3'h0, tmr_q};
         REG_ROUTE: rdata_d = {4'h0, route_q};
         REG_STATE: rdata_d = {5'h0, code_q};
         default:
         begin
            if (reg_addr_i >= REG_BUF_FIRST && reg_addr_i < REG_BUF_FIRST + 8'(NBUF))
            begin
               rdata_d = {7'h00, buf_q[3'(reg_addr_i - REG_BUF_FIRST)]};
            end
         end
      endcase
   end

   // Loop state machine
   always_comb
   begin
      state_d = state_q;
      cp_tri_d = cp_tri_q;
      lock_d = lock_q;
      dac_force_d = dac_force_q;
      div_rst_d = 1'b0;
      imp_d = imp_q;
      lock_cnt_d = lock_cnt_q;
      dac_code_d = dac_code_q;
      case (state_q)
         ST_INIT:
         begin
            state_d = ST_PRELOAD;
         end
         ST_PRELOAD:
         begin
            if (ref_ready)
            begin
               state_d = ST_ACQUIRE;
               cp_tri_d = 1'b0;
               lock_cnt_d = '0;
            end
         end
         ST_ACQUIRE:
         begin
            if (phase_err_large_i)
            begin
               lock_cnt_d = '0;
            end
            else if (lock_cnt_q + CNT_W'(1) >= lock_target)
            begin
               lock_d = 1'b1;
               state_d = ST_LOCKED;
            end
            else
            begin
               lock_cnt_d = lock_cnt_q + CNT_W'(1);
            end
         end
         ST_LOCKED:
         begin
            if (phase_err_large_i || signal_missing_flag_i || ref_switch_req_i)
            begin
               cp_tri_d = 1'b1;
               lock_d = 1'b0;
               state_d = ST_HOLD_ENTRY;
            end
         end
         ST_HOLD_ENTRY:
         begin
            cp_tri_d = 1'b1;
            dac_force_d = use_dac;
            dac_code_d = avg_code;
            state_d = ST_HOLD;
         end
         ST_HOLD:
         begin
            cp_tri_d = 1'b1;
            if (exit_ok)
            begin
               case (exit_act)
                  ACT_SLIP:
                  begin
                     state_d = ST_EXIT_SLIP;
                  end
                  ACT_DAC:
                  begin
                     div_rst_d = 1'b1;
                     cp_tri_d = 1'b0;
                     imp_d = IMP_LOW;
                     state_d = ST_EXIT_RELEASE;
                  end
                  default:
                  begin
                     div_rst_d = 1'b1;
                     cp_tri_d = 1'b0;
                     dac_force_d = 1'b0;
                     lock_cnt_d = '0;
                     state_d = ST_ACQUIRE;
                  end
               endcase
            end
         end
         ST_EXIT_SLIP:
         begin
            if (cycle_slip_i)
            begin
               cp_tri_d = 1'b0;
               dac_force_d = 1'b0;
               lock_cnt_d = '0;
               state_d = ST_ACQUIRE;
            end
         end
         ST_EXIT_RELEASE:
         begin
            if (imp_q == IMP_HIGH)
            begin
               dac_force_d = 1'b0;
               lock_cnt_d = '0;
               state_d = ST_ACQUIRE;
            end
            else
            begin
               imp_d = imp_q + IMP_W'(1);
            end
         end
         default:
         begin
            state_d = ST_INIT;
         end
      endcase
      if (phase_err_large_i)
      begin
         lock_d = 1'b0;
      end
   end

   // State code for readback
   always_comb
   begin
      case (state_d)
         ST_INIT: code_d = CODE_INIT;
         ST_PRELOAD: code_d = CODE_PRELOAD;
         ST_ACQUIRE: code_d = CODE_ACQUIRE;
         ST_LOCKED: code_d = CODE_LOCKED;
         ST_HOLD_ENTRY: code_d = CODE_HOLD_ENTRY;
         ST_HOLD: code_d = CODE_HOLD;
         default: code_d = CODE_EXIT;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= ST_INIT;
         cp_tri_q <= 1'b1;
         lock_q <= 1'b0;
         dac_force_q <= 1'b0;
         div_rst_q <= 1'b0;
         imp_q <= IMP_LOW;
         lock_cnt_q <= '0;
         dac_code_q <= '0;
         exit_cfg_q <= EXIT_CFG_RST;
         hold_cfg_q <= HOLD_CFG_RST;
         tmr_q <= LOCK_TMR_RST;
         route_q <= ROUTE_RST;
         buf_q <= '0;
         rdata_q <= 8'h00;
         code_q <= CODE_INIT;
      end
      else
      begin
         state_q <= state_d;
         cp_tri_q <= cp_tri_d;
         lock_q <= lock_d;
         dac_force_q <= dac_force_d;
         div_rst_q <= div_rst_d;
         imp_q <= imp_d;
         lock_cnt_q <= lock_cnt_d;
         dac_code_q <= dac_code_d;
         exit_cfg_q <= exit_cfg_d;
         hold_cfg_q <= hold_cfg_d;
         tmr_q <= tmr_d;
         route_q <= route_d;
         buf_q <= buf_d;
         rdata_q <= rdata_d;
         code_q <= code_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign charge_pump_tristate_o = cp_tri_q;
   assign lock_detect_o = lock_q;
   assign dac_force_o = dac_force_q;
   assign dac_code_o = dac_code_q;
   assign dac_impedance_o = imp_q;
   assign divider_reset_o = div_rst_q;
   assign ref_buffer_enable_o = buf_q;
   assign reference_route_select_o = route_q;
   assign loop_state_code_o = code_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_hold_exit_reset;
      state_q == ST_HOLD && exit_ok && exit_act == ACT_RESET;
   endsequence

   sequence s_reset_pulse;
      divider_reset_o ##1 !divider_reset_o;
   endsequence

   property p_pe_tristate;
      state_q == ST_LOCKED && phase_err_large_i |=> charge_pump_tristate_o;
   endproperty
   a_pe_tristate: assert property (p_pe_tristate) else $error("pump not tristated on error");

   property p_pe_unlock;
      phase_err_large_i |=> !lock_detect_o;
   endproperty
   a_pe_unlock: assert property (p_pe_unlock) else $error("lock kept after large error");

   property p_hold_tri;
      state_q == ST_HOLD |-> charge_pump_tristate_o;
   endproperty
   a_hold_tri: assert property (p_hold_tri) else $error("pump active in holdover");

   // Mode is latched on entry; a later write to the mode bit must not move it
   property p_dac_mode;
      $rose(state_q == ST_HOLD) |-> dac_force_o == $past(use_dac);
   endproperty
   a_dac_mode: assert property (p_dac_mode) else $error("DAC force differs from mode");

   property p_dac_hold;
      dac_force_o && $past(dac_force_o) |-> $stable(dac_code_o);
   endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("forced DAC code moved");

   property p_avg_freeze;
      !lock_detect_o |=> $stable(avg_code);
   endproperty
   a_avg_freeze: assert property (p_avg_freeze) else $error("average moved while unlocked");

   property p_exit_reset;
      s_hold_exit_reset |=> s_reset_pulse and (state_q == ST_ACQUIRE && !charge_pump_tristate_o);
   endproperty
   a_exit_reset: assert property (p_exit_reset) else $error("divider reset exit wrong");

   property p_slip;
      state_q == ST_EXIT_SLIP && !cycle_slip_i |=> charge_pump_tristate_o;
   endproperty
   a_slip: assert property (p_slip) else $error("pump released before slip");

   property p_release_ramp;
      state_q == ST_EXIT_RELEASE && $past(state_q) == ST_EXIT_RELEASE
         |-> dac_impedance_o == $past(dac_impedance_o) + IMP_W'(1);
   endproperty
   a_release_ramp: assert property (p_release_ramp) else $error("impedance not stepping");

   property p_code;
      ##1 1'b1 |-> (state_q == ST_HOLD) == (loop_state_code_o == CODE_HOLD);
   endproperty
   a_code: assert property (p_code) else $error("state code mismatch");

endmodule

`default_nettype wire

// ===== sim/hoc_loop_model.sv
// Purpose: Far side of the holdover controller: detector, pump and tuning node
// Assumes: Bench commands change at the falling edge of clk_i
// Notes: Tuning node drifts while the pump is tristated and the DAC is not forcing

`timescale 1ns/1ps
`default_nettype none

module hoc_loop_model
   import hoc_pkg::*;
#(
   parameter logic [CONV_W-1:0] TARGET = 7'h50
)
(
   // Clock
   input wire logic clk_i,
   // Bench commands
   input wire logic ref_lost_i,
   input wire logic skew_i,
   input wire logic slip_i,
   // Controls from the controller
   input wire logic charge_pump_tristate_i,
   input wire logic dac_force_i,
   input wire logic [CONV_W-1:0] dac_code_i,
   // Detector and converter
   output logic phase_err_large_o,
   output logic cycle_slip_o,
   output logic [CONV_W-1:0] adc_code_o
);
   logic [CONV_W-1:0] tuning_voltage = 7'h00;

   // Leakage moves the node when nobody drives it, so a missed hold shows up
   always @(negedge clk_i)
   begin
      if (dac_force_i)
      begin
         tuning_voltage <= dac_code_i;
      end
      else if (!charge_pump_tristate_i)
      begin
         tuning_voltage <= TARGET;
      end
      else
      begin
         tuning_voltage <= tuning_voltage + 7'h01;
      end
   end

   assign adc_code_o = tuning_voltage;
   assign phase_err_large_o = ref_lost_i | skew_i;
   assign cycle_slip_o = slip_i;
endmodule

`default_nettype wire

// ===== sim/tb_pll_holdover_control_fsm.sv
// Purpose: Self-checking bench for the holdover controller
// Assumes: Inputs change at the falling edge; outputs are read there too
// Notes: Lock timer is set to 2 so lock comes after four quiet cycles

`timescale 1ns/1ps
`default_nettype none

module tb_pll_holdover_control_fsm
   import hoc_pkg::*;
;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic signal_missing_flag_i = 1'b0;
   logic ref_switch_req_i = 1'b0;
   logic ref_lost = 1'b0;
   logic skew = 1'b0;
   logic slip = 1'b0;
   logic phase_err_large_i;
   logic cycle_slip_i;
   logic [CONV_W-1:0] adc_code_i;
   logic [7:0] reg_rdata_o;
   logic charge_pump_tristate_o;
   logic lock_detect_o;
   logic dac_force_o;
   logic [CONV_W-1:0] dac_code_o;
   logic [IMP_W-1:0] dac_impedance_o;
   logic divider_reset_o;
   logic [NBUF-1:0] ref_buffer_enable_o;
   logic [ROUTE_W-1:0] reference_route_select_o;
   logic [2:0] loop_state_code_o;
   int failures = 0;
   int check_count = 0;

   initial
   begin
      forever #25 clk_i = ~clk_i;
   end

   hoc_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
      .phase_err_large_i(phase_err_large_i), .signal_missing_flag_i(signal_missing_flag_i),
      .ref_switch_req_i(ref_switch_req_i), .cycle_slip_i(cycle_slip_i),
      .adc_code_i(adc_code_i), .charge_pump_tristate_o(charge_pump_tristate_o),
      .lock_detect_o(lock_detect_o), .dac_force_o(dac_force_o), .dac_code_o(dac_code_o),
      .dac_impedance_o(dac_impedance_o), .divider_reset_o(divider_reset_o),
      .ref_buffer_enable_o(ref_buffer_enable_o),
      .reference_route_select_o(reference_route_select_o),
      .loop_state_code_o(loop_state_code_o));

   hoc_loop_model model (.clk_i(clk_i), .ref_lost_i(ref_lost), .skew_i(skew), .slip_i(slip),
      .charge_pump_tristate_i(charge_pump_tristate_o), .dac_force_i(dac_force_o),
      .dac_code_i(dac_code_o), .phase_err_large_o(phase_err_large_i),
      .cycle_slip_o(cycle_slip_i), .adc_code_o(adc_code_i));

   task automatic wrap_up();
      $display("Checks %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic out(input logic tri_e, input logic lock_e, input logic [2:0] code_e);
      chk({3'h0, charge_pump_tristate_o, lock_detect_o, loop_state_code_o},
         {3'h0, tri_e, lock_e, code_e}, "pump, lock, state");
   endtask

   task automatic dac(input logic force_e, input logic div_e);
      chk({6'h00, dac_force_o, divider_reset_o}, {6'h00, force_e, div_e}, "force, div reset");
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      cyc(1);
      reg_wr_i = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_i = a;
      cyc(2);
      chk(reg_rdata_o, exp, "register read");
   endtask

   task automatic wait_code(input logic [2:0] code);
      int n;
      n = 0;
      while (loop_state_code_o !== code && n < 600)
      begin
         cyc(1);
         n++;
      end
      chk({5'h00, loop_state_code_o}, {5'h00, code}, "state wait");
      if (n >= 600)
      begin
         wrap_up();
      end
   endtask

   task automatic t_reset_regs();
      out(1'b1, 1'b0, CODE_INIT);
      sys_rst_i = 1'b0;
      rd(REG_EXIT_CFG, EXIT_CFG_RST);
      rd(REG_HOLD_CFG, HOLD_CFG_RST);
      rd(REG_LOCK_TMR, {3'h0, LOCK_TMR_RST});
      rd(REG_ROUTE, {4'h0, ROUTE_RST});
      rd(REG_BUF_FIRST, 8'h00);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
      wr(REG_STATE, 8'h07);
      rd(REG_STATE, {5'h00, CODE_PRELOAD});
      wr(REG_LOCK_TMR, 8'h02);
      wr(REG_ROUTE, 8'h01);
      cyc(3);
      rd(REG_STATE, {5'h00, CODE_PRELOAD});
      // Dual-function inputs stay in reference mode, so enabling buffers is enough
      for (int i = 0; i < NBUF; i++)
      begin
         wr(REG_BUF_FIRST + 8'(i), 8'h01);
      end
      chk({3'h0, ref_buffer_enable_o}, 8'h1f, "buffer enables");
      chk({4'h0, reference_route_select_o}, 8'h01, "route select");
      rd(REG_BUF_FIRST + 8'h04, 8'h01);
   endtask

   task automatic t_dac_release();
      wr(REG_HOLD_CFG, 8'h04);
      wr(REG_EXIT_CFG, 8'h0c);
      wait_code(CODE_LOCKED);
      cyc(400);
      rd(REG_STATE, {5'h00, CODE_LOCKED});
      signal_missing_flag_i = 1'b1;
      cyc(1);
      out(1'b1, 1'b0, CODE_HOLD_ENTRY);
      cyc(1);
      out(1'b1, 1'b0, CODE_HOLD);
      dac(1'b1, 1'b0);
      chk({1'b0, dac_code_o}, 8'h50, "held code");
      cyc(6);
      chk({1'b0, dac_code_o}, 8'h50, "held code steady");
      signal_missing_flag_i = 1'b0;
      cyc(1);
      out(1'b0, 1'b0, CODE_EXIT);
      dac(1'b1, 1'b1);
      chk({5'h00, dac_impedance_o}, {5'h00, IMP_LOW}, "impedance start");
      for (int i = 1; i < 8; i++)
      begin
         cyc(1);
         chk({5'h00, dac_impedance_o}, 8'(i), "impedance step");
         dac(1'b1, 1'b0);
      end
      cyc(1);
      dac(1'b0, 1'b0);
      out(1'b0, 1'b0, CODE_ACQUIRE);
   endtask

   task automatic t_div_reset();
      wr(REG_HOLD_CFG, 8'h00);
      wr(REG_EXIT_CFG, 8'h00);
      wait_code(CODE_LOCKED);
      out(1'b0, 1'b1, CODE_LOCKED);
      ref_lost = 1'b1;
      cyc(1);
      out(1'b1, 1'b0, CODE_HOLD_ENTRY);
      ref_lost = 1'b0;
      signal_missing_flag_i = 1'b1;
      cyc(1);
      dac(1'b0, 1'b0);
      cyc(8);
      out(1'b1, 1'b0, CODE_HOLD);
      signal_missing_flag_i = 1'b0;
      cyc(1);
      out(1'b0, 1'b0, CODE_ACQUIRE);
      dac(1'b0, 1'b1);
      cyc(1);
      dac(1'b0, 1'b0);
      skew = 1'b1;
      cyc(6);
      out(1'b0, 1'b0, CODE_ACQUIRE);
      skew = 1'b0;
      cyc(2);
      out(1'b0, 1'b0, CODE_ACQUIRE);
      cyc(1);
      out(1'b0, 1'b0, CODE_ACQUIRE);
      cyc(1);
      out(1'b0, 1'b1, CODE_LOCKED);
   endtask

   task automatic t_slip_exit();
      wr(REG_EXIT_CFG, 8'h05);
      wait_code(CODE_LOCKED);
      ref_switch_req_i = 1'b1;
      cyc(1);
      ref_switch_req_i = 1'b0;
      out(1'b1, 1'b0, CODE_HOLD_ENTRY);
      skew = 1'b1;
      cyc(5);
      out(1'b1, 1'b0, CODE_HOLD);
      skew = 1'b0;
      cyc(2);
      out(1'b1, 1'b0, CODE_EXIT);
      cyc(5);
      out(1'b1, 1'b0, CODE_EXIT);
      slip = 1'b1;
      cyc(1);
      slip = 1'b0;
      out(1'b0, 1'b0, CODE_ACQUIRE);
      dac(1'b0, 1'b0);
   endtask

   initial
   begin
      cyc(4);
      t_reset_regs();
      t_dac_release();
      t_div_reset();
      t_slip_exit();
      wrap_up();
   end
endmodule

`default_nettype wire
